// >>> verification/cell_seq_chk.sv
// Purpose: Port assertions for the measurement sequencer.
// Assumes: One clock domain, synchronous reset.
// Notes:   Slot gaps and last channel are tracked in helper logic.
`timescale 1ns/10ps
module cell_seq_chk
  import cell_seq_pkg::*;
#(
  parameter int NUM_CELLS     = 5,
  parameter int SLOT_SLOW_CYC = 20,
  parameter int SLOT_FAST_CYC = 10
)(
  input logic         core_clk,
  input logic         srst,
  input logic         fast_slot,
  input logic [4:0]   aux_enable,
  input logic [4:0]   cell_in_use,
  input channel_t     mux_sel,
  input logic         conv_start,
  input logic         conv_done,
  input logic [23:0]  conv_raw,
  input logic [4:0]   cell_prot_enable,
  input cell_report_t cell_report [NUM_CELLS],
  input logic [3:0]   loop_slots
);
  ////////////////////////////////////////////////////////////
  channel_t    last_reg;
  logic [31:0] gap_reg;
  logic [3:0]  aux_n;
  logic [31:0] slot_len;
  always_comb begin
    aux_n = ($countones(aux_enable) > 3) ? 4'h3 : 4'($countones(aux_enable));
    slot_len = fast_slot ? SLOT_FAST_CYC : SLOT_SLOW_CYC;
  end
  // The gap restarts at every start so idle slots show as whole multiples.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      last_reg <= CH_IDLE;
      gap_reg  <= '0;
    end else begin
      gap_reg <= conv_start ? 32'h1 : gap_reg + 32'h1;
      if (conv_start) last_reg <= mux_sel;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////
  prot_follow_a: assert property (cell_prot_enable == cell_in_use)
    else $error("protection enable differs from cell mask");
  slot_count_a: assert property (loop_slots == 4'h7 + aux_n)
    else $error("loop slot count wrong");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  slot_gap_a: assert property (conv_start && last_reg != CH_IDLE
    |-> gap_reg % slot_len == 0) else $error("slot length wrong");
  cell_order_a: assert property (conv_start && last_reg inside
    {[CH_CELL1:CH_CELL4]} |-> mux_sel == last_reg + 1)
    else $error("cell slots out of order");
  pin_slot_a: assert property (conv_start && last_reg == CH_CELL5
    |-> mux_sel inside {CH_TOP_CELL, CH_PACK, CH_LOAD})
    else $error("pin slot missing after cells");
  int_slot_a: assert property (conv_start && last_reg inside
    {CH_TOP_CELL, CH_PACK, CH_LOAD}
    |-> mux_sel inside {CH_DIE_TEMP, CH_REF, CH_GND})
    else $error("internal slot missing after pin slot");
  raw_store_a: assert property (conv_done && mux_sel == CH_CELL1
    |-> ##2 cell_report[0].raw32 == 32'($signed($past(conv_raw, 2))))
    else $error("raw cell word not stored sign extended");
endmodule
bind cell_voltage_measurement_sequencer cell_seq_chk #(
  .NUM_CELLS(NUM_CELLS), .SLOT_SLOW_CYC(SLOT_SLOW_CYC),
  .SLOT_FAST_CYC(SLOT_FAST_CYC)) cell_seq_chk_inst (
  .core_clk(core_clk), .srst(srst), .fast_slot(fast_slot),
  .aux_enable(aux_enable), .cell_in_use(cell_in_use),
  .mux_sel(mux_sel), .conv_start(conv_start), .conv_done(conv_done),
  .conv_raw(conv_raw), .cell_prot_enable(cell_prot_enable),
  .cell_report(cell_report), .loop_slots(loop_slots));

// >>> verification/conv_model.sv
// Purpose: Behavioural shared converter answering each start.
// Assumes: One done pulse per start, well inside the shortest slot.
// Notes:   Data line carries a toggling pattern outside done cycles.
`timescale 1ns/10ps
module conv_model
  import cell_seq_pkg::*;
(
  input  logic        core_clk,
  input  logic        slow,
  input  logic        conv_start,
  input  channel_t    mux_sel,
  output logic        conv_done,
  output logic [23:0] conv_raw
);
  ////////////////////////////////////////////////////////////
  logic [2:0] wait_reg = 3'h0;
  channel_t   chan_reg = CH_IDLE;
  initial begin
    conv_done = 1'b0;
    conv_raw  = 24'h0;
  end
  always @(posedge core_clk) begin
    conv_done <= 1'b0;
    conv_raw  <= ~conv_raw;
    if (conv_start) begin
      wait_reg <= slow ? 3'h7 : 3'h1;
      chan_reg <= mux_sel;
    end else if (wait_reg != 3'h0) begin
      wait_reg <= wait_reg - 3'h1;
      // Sign bit set so the raw word must be sign extended.
      if (wait_reg == 3'h1) begin
        conv_done <= 1'b1;
        conv_raw  <= {4'h8, 16'h0, 4'(chan_reg)};
      end
    end
  end
endmodule

// >>> verification/tb_cell_voltage_measurement_sequencer.sv
// Purpose: Self-checking bench for the measurement sequencer.
// Assumes: Slots shortened to 20 and 10 cycles.
// Notes:   Pin and internal rotations start at top cell and die sensor.
`timescale 1ns/10ps
module tb_cell_voltage_measurement_sequencer
  import cell_seq_pkg::*;
;
  logic core_clk = 0, srst = 1, run = 0, fast_slot = 0, slow = 0;
  logic [3:0] idle_slots = 0;
  logic [4:0] aux_enable = 0, cell_in_use = 0;
  logic [23:0] cc_current = 0, conv_raw;
  logic conv_start, conv_done, full_set_done;
  channel_t mux_sel;
  logic [2:0] mux_aux_idx;
  logic [4:0] cell_prot_enable;
  cell_report_t cell_report [5];
  logic [31:0] other_raw [13];
  logic [3:0] loop_slots;
  int mismatches = 0, cmp_count = 0, cyc = 0;
  ////////////////////////////////////////////////////////////
  cell_voltage_measurement_sequencer #(.SLOT_SLOW_CYC(20),
    .SLOT_FAST_CYC(10)) cell_voltage_measurement_sequencer_inst (
    .core_clk(core_clk), .srst(srst), .run(run), .fast_slot(fast_slot),
    .idle_slots(idle_slots), .aux_enable(aux_enable),
    .cell_in_use(cell_in_use), .cal_gain(16'h8000),
    .cal_offset(16'h0000), .cc_current(cc_current), .mux_sel(mux_sel),
    .mux_aux_idx(mux_aux_idx), .conv_start(conv_start),
    .conv_done(conv_done), .conv_raw(conv_raw),
    .cell_prot_enable(cell_prot_enable), .cell_report(cell_report),
    .other_raw(other_raw), .full_set_done(full_set_done),
    .loop_slots(loop_slots));
  conv_model conv_model_inst (.core_clk(core_clk), .slow(slow),
    .conv_start(conv_start), .mux_sel(mux_sel),
    .conv_done(conv_done), .conv_raw(conv_raw));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Each loop scenario restarts from reset, which also covers a reset
  // landing in the middle of running traffic.
  task automatic t_loop(logic fast, logic [3:0] idle, logic slw);
    int gap, dones, slot, k, lp;
    slot = fast ? 10 : 20;
    dones = 0;
    @(posedge core_clk);
    srst <= 1;
    run <= 0;
    repeat (16) @(posedge core_clk);
    srst <= 0;
    fast_slot <= fast;
    idle_slots <= idle;
    slow <= slw;
    cell_in_use <= 5'h0b;
    cc_current <= 24'h000123;
    run <= 1;
    for (int i = 0; i < 22; i++) begin
      gap = 0;
      do begin
        @(negedge core_clk);
        gap++;
        if (full_set_done === 1'b1) dones++;
      end while (conv_start !== 1'b1 && gap < 400);
      k = i % 7;
      lp = (i / 7) % 3;
      if (k < 5) check("cell slot", mux_sel, k);
      else if (k == 5) check("pin slot", mux_sel, 5 + lp);
      else check("internal slot", mux_sel, 8 + lp);
      if (i > 0) check("gap", gap, (k == 0) ? (1 + idle) * slot : slot);
    end
    check("full set", dones, 1);
    for (int c = 0; c < 5; c++) begin
      check("raw32", cell_report[c].raw32, 32'hff800000 + c);
      check("current", cell_report[c].current32, 32'h123);
      // Half gain on the model word leaves half the channel code.
      check("mv", cell_report[c].mv, c / 2);
    end
    for (int c = 6; c < 10; c++) begin
      check("other raw", other_raw[c], 32'hff800000 + c);
    end
    check("top raw", other_raw[5], 32'hff800005);
    check("gnd raw", other_raw[10], 32'hff80000a);
    check("prot", cell_prot_enable, 5'h0b);
    $display("loop test done fast %0d idle %0d", fast, idle);
  endtask
  task automatic t_slots();
    for (int n = 0; n < 6; n++) begin
      @(posedge core_clk);
      aux_enable <= 5'((1 << n) - 1);
      @(negedge core_clk);
      check("loop slots", loop_slots, 7 + ((n > 3) ? 3 : n));
    end
    aux_enable <= 5'h00;
    $display("slot count test done");
  endtask
  // Two auxiliary inputs, 0 and 2, give a nine slot loop.
  task automatic t_aux();
    int gap;
    @(posedge core_clk);
    srst <= 1;
    run <= 0;
    aux_enable <= 5'h05;
    repeat (16) @(posedge core_clk);
    srst <= 0;
    fast_slot <= 1'b1;
    idle_slots <= 4'h0;
    slow <= 1'b0;
    run <= 1;
    for (int i = 0; i < 19; i++) begin
      gap = 0;
      do begin
        @(negedge core_clk);
        gap++;
      end while (conv_start !== 1'b1 && gap < 400);
      if (i > 0) check("aux gap", gap, 10);
      if (i % 9 == 7) begin
        check("aux slot", mux_sel, CH_AUX);
        check("aux index", mux_aux_idx, 0);
      end else if (i % 9 == 8) begin
        check("aux slot", mux_sel, CH_AUX);
        check("aux index", mux_aux_idx, 2);
      end
    end
    check("aux raw", other_raw[11], 32'hff80000b);
    check("aux loop slots", loop_slots, 9);
    $display("aux test done");
  endtask
  initial begin
    t_slots();
    t_loop(1'b0, 4'h0, 1'b0);
    t_loop(1'b1, 4'h2, 1'b1);
    t_aux();
    summarize();
  end
endmodule

// >>> verilog/cell_result_convert.sv
// Purpose: Turns a raw conversion into corrected millivolts and raw words.
// Assumes: Gain is an unsigned Q0.16 fraction times full scale, offset in mV.
// Notes:   Result is registered, one cycle after the input strobe.
`timescale 1ns/10ps
`include "cell_seq_consts.svh"
module cell_result_convert
  import cell_seq_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        in_valid,
  input  wire logic [23:0] raw,
  input  wire logic [15:0] gain,
  input  wire logic [15:0] offset,
  output logic             out_valid,
  output logic [15:0]      mv,
  output logic [31:0]      raw32
);
  typedef struct packed {
    logic        v;
    logic [15:0] mv;
    logic [31:0] raw32;
  } conv_state_t;

  conv_state_t st_reg;
  conv_state_t st_next;
  logic [39:0] prod;
  logic [23:0] scaled;

  always_comb begin
    st_next = st_reg;
    prod    = $signed(raw) * $signed({1'b0, gain});
    scaled  = prod[39:16];
    st_next.v = in_valid;
    if (in_valid) begin
      st_next.mv    = scaled[15:0] + offset; // R3
      st_next.raw32 = {{8{raw[`RAW_SIGN_BIT]}}, raw}; // R4
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_valid = st_reg.v;
  assign mv        = st_reg.mv;
  assign raw32     = st_reg.raw32;
endmodule

// >>> verilog/cell_seq_consts.svh
// Purpose: Constants for the cell voltage measurement sequencer.
// Assumes: core_clk at 50 MHz.
// Notes:   Offsets of none; timing counts derive from times in microseconds.
// How it works
// R1 - One muxed converter serves every channel.
// R2 - Cell reading is adjacent input pair difference.
// R3 - Cells corrected, published as 16-bit millivolts.
// R4 - Raw 24-bit result readable as 32 bits.
// R5 - Loop: five cells, pin, internal, inputs.
// R6 - Full measurement set every three loops.
// R7 - Loop holds 7 to 10 slots.
// R8 - Slot lasts 3 ms or 1.5 ms.
// R9 - Slow speed appends idle slots per loop; the code appends idle_slots at either slot length.
// R10 - Unused cell inputs get protections disabled.
// R11 - All cell inputs published in both formats.
// R12 - Interconnect voltage reported with synchronized current.
// R13 - Synchronous current stored beside each cell.
// R14 - Shared slots rotate round-robin once per loop.
`ifndef CELL_SEQ_CONSTS_SVH
`define CELL_SEQ_CONSTS_SVH
`define CLK_FREQ_KHZ       50000
`define SLOT_SLOW_US       3000
`define SLOT_FAST_US       1500
`define SLOT_SLOW_CYC      ((`SLOT_SLOW_US * `CLK_FREQ_KHZ) / 1000)
`define SLOT_FAST_CYC      ((`SLOT_FAST_US * `CLK_FREQ_KHZ) / 1000)
`define NUM_CELLS          5
`define MIN_CELLS_SERIES   3
`define MAX_AUX_SLOTS      3
`define BASE_SLOTS         7
`define ROT_STEPS          3
`define CELL_MASK_RESET    5'h1f
`define RAW_SIGN_BIT       23
`endif

// >>> verilog/cell_seq_pkg.sv
// Purpose: Types shared by the sequencer and its result converter.
// Assumes: Constants header defines the counts.
// Notes:   Channel codes cover every input the mux can select.
package cell_seq_pkg;
  typedef enum logic [3:0] {
    CH_CELL1, CH_CELL2, CH_CELL3, CH_CELL4, CH_CELL5,
    CH_TOP_CELL, CH_PACK, CH_LOAD,
    CH_DIE_TEMP, CH_REF, CH_GND,
    CH_AUX, CH_IDLE
  } channel_t;

  typedef struct packed {
    logic        valid;
    channel_t    chan;
    logic [2:0]  aux_idx;
    logic [23:0] raw;
    logic [23:0] current;
  } conv_result_t;

  typedef struct packed {
    logic [15:0] mv;
    logic [31:0] raw32;
    logic [31:0] current32;
  } cell_report_t;
endpackage

// >>> verilog/cell_voltage_measurement_sequencer.sv
// Purpose: Steps the shared voltage converter through the measurement loop.
// Assumes: Converter answers each start with one done pulse within a slot.
// Notes:   Results are held in flip-flops for the host command logic.
`timescale 1ns/10ps
`include "cell_seq_consts.svh"
module cell_voltage_measurement_sequencer
  import cell_seq_pkg::*;
#(
  parameter int NUM_CELLS = `NUM_CELLS,
  parameter int SLOT_SLOW_CYC = `SLOT_SLOW_CYC,
  parameter int SLOT_FAST_CYC = `SLOT_FAST_CYC
)(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        run,
  input  wire logic        fast_slot,
  input  wire logic [3:0]  idle_slots,
  input  wire logic [4:0]  aux_enable,
  input  wire logic [4:0]  cell_in_use,
  input  wire logic [15:0] cal_gain,
  input  wire logic [15:0] cal_offset,
  input  wire logic [23:0] cc_current,
  output channel_t         mux_sel,
  output logic [2:0]       mux_aux_idx,
  output logic             conv_start,
  input  wire logic        conv_done,
  input  wire logic [23:0] conv_raw,
  output logic [4:0]       cell_prot_enable,
  output cell_report_t     cell_report [NUM_CELLS],
  output logic [31:0]      other_raw [13],
  output logic             full_set_done,
  output logic [3:0]       loop_slots
);
  // Refused while elaborating; the slot timer is only 18 bits wide.
  if (NUM_CELLS != `NUM_CELLS) begin : g_bad_cells
    $error("Cell count is fixed at five.");
  end
  if (SLOT_FAST_CYC < 2 || SLOT_SLOW_CYC < SLOT_FAST_CYC) begin : g_bad_slot
    $error("Slot counts out of range.");
  end
  if (SLOT_SLOW_CYC > 262143) begin : g_bad_tmr
    $error("Slow slot count does not fit the slot timer.");
  end

  typedef enum logic [1:0] {S_IDLE, S_MEAS, S_WAIT, S_PAUSE} phase_t;

  typedef struct packed {
    phase_t      phase;
    logic [3:0]  slot;
    logic [3:0]  idle_cnt;
    logic [17:0] tmr;
    logic [1:0]  rot;
    logic [1:0]  loops;
    logic [2:0]  aux_ptr;
    logic [2:0]  aux_done;
    logic [2:0]  aux_cur;
    logic        start;
    logic        full;
    channel_t    chan;
    logic [23:0] cur_snap;
  } seq_state_t;

  seq_state_t st_reg;
  seq_state_t st_next;
  logic [2:0]  n_aux;
  logic [3:0]  slots_in_loop;
  logic [17:0] slot_len;
  logic        cv_valid;
  logic [15:0] cv_mv;
  logic [31:0] cv_raw32;
  logic [23:0] pend_cur_reg;
  channel_t    pend_chan_reg;

  // Counts enabled auxiliary inputs, capped at the three loop slots.
  function automatic logic [2:0] count_aux(input logic [4:0] en);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 0; i < 5; i++) begin
      if (en[i] && c < 3'h3) c = c + 3'h1;
    end
    return c;
  endfunction

  // Next enabled auxiliary channel at or after a start position.
  function automatic logic [2:0] next_aux(input logic [4:0] en,
                                          input logic [2:0] from);
    logic [2:0] r;
    logic       hit;
    r   = from;
    hit = 1'b0;
    for (int k = 0; k < 5; k++) begin
      if (!hit && en[(32'(from) + k) % 5]) begin
        r   = 3'((32'(from) + k) % 5);
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  // Channel selected by a slot number given the rotation step.
  function automatic channel_t slot_chan(input logic [3:0] s,
                                         input logic [1:0] r);
    channel_t c;
    c = CH_AUX;
    if (s < 4'h5) c = channel_t'(s); // R5
    else if (s == 4'h5) c = channel_t'(4'(CH_TOP_CELL) + 4'(r)); // R14
    else if (s == 4'h6) c = channel_t'(4'(CH_DIE_TEMP) + 4'(r)); // R14
    return c;
  endfunction

  assign n_aux         = count_aux(aux_enable);
  assign slots_in_loop = 4'(`BASE_SLOTS) + 4'(n_aux); // R7
  assign slot_len      = fast_slot ? 18'(SLOT_FAST_CYC)
                                   : 18'(SLOT_SLOW_CYC); // R8

  always_comb begin
    st_next       = st_reg;
    st_next.start = 1'b0;
    st_next.full  = 1'b0;
    case (st_reg.phase)
      S_IDLE: begin
        if (run) begin
          st_next.phase = S_MEAS;
          st_next.slot  = 4'h0;
        end
      end
      S_MEAS: begin
        // One converter, one channel per slot.
        st_next.chan     = slot_chan(st_reg.slot, st_reg.rot); // R1
        st_next.aux_cur  = next_aux(aux_enable, st_reg.aux_ptr);
        st_next.cur_snap = cc_current; // R13
        st_next.start    = 1'b1;
        // The start cycle counts as the slot's first, so wait one less.
        st_next.tmr      = slot_len - 18'h2; // R8
        st_next.phase    = S_WAIT;
      end
      S_WAIT: begin
        if (st_reg.tmr != 18'h0) begin
          st_next.tmr = st_reg.tmr - 18'h1;
        end else if (st_reg.chan == CH_AUX) begin
          st_next.aux_ptr = 3'((32'(st_reg.aux_cur) + 1) % 5);
          st_next.aux_done = st_reg.aux_done + 3'h1;
        end
        if (st_reg.tmr == 18'h0) begin
          if (st_reg.slot + 4'h1 < slots_in_loop) begin
            st_next.slot  = st_reg.slot + 4'h1;
            st_next.phase = S_MEAS;
          end else begin
            st_next.slot     = 4'h0;
            st_next.idle_cnt = idle_slots;
            st_next.tmr      = slot_len - 18'h1;
            st_next.rot      = (st_reg.rot == 2'(`ROT_STEPS - 1)) ?
                               2'h0 : st_reg.rot + 2'h1; // R14
            st_next.loops    = (st_reg.loops == 2'(`ROT_STEPS - 1)) ?
                               2'h0 : st_reg.loops + 2'h1;
            st_next.full     = (st_reg.loops == 2'(`ROT_STEPS - 1)); // R6
            st_next.chan     = CH_IDLE;
            st_next.phase    = (idle_slots != 4'h0) ? S_PAUSE
                             : (run ? S_MEAS : S_IDLE);
          end
        end
      end
      S_PAUSE: begin
        // Idle slots stretch the loop to cut converter power.
        if (st_reg.tmr != 18'h0) begin
          st_next.tmr = st_reg.tmr - 18'h1;
        end else if (st_reg.idle_cnt > 4'h1) begin
          st_next.idle_cnt = st_reg.idle_cnt - 4'h1;
          st_next.tmr      = slot_len - 18'h1; // R9
        end else begin
          st_next.idle_cnt = 4'h0;
          st_next.phase    = run ? S_MEAS : S_IDLE; // R9
        end
      end
      default: st_next.phase = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '{phase: S_IDLE, chan: CH_IDLE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Channel and current stay with the conversion until its result returns.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pend_chan_reg <= CH_IDLE;
      pend_cur_reg  <= 24'h0;
    end else if (conv_done) begin
      pend_chan_reg <= st_reg.chan;
      pend_cur_reg  <= st_reg.cur_snap;
    end
  end

  logic [2:0] aux_lat_reg;
  always_ff @(posedge core_clk) begin
    if (srst) aux_lat_reg <= 3'h0;
    else if (conv_done) aux_lat_reg <= st_reg.aux_cur;
  end

  // Corrections apply only to cells; pin, internal and auxiliary inputs 0 and 1 keep the raw word.
  cell_result_convert u_conv (
    .core_clk  (core_clk),
    .srst      (srst),
    .in_valid  (conv_done),
    .raw       (conv_raw),
    .gain      (cal_gain),
    .offset    (cal_offset),
    .out_valid (cv_valid),
    .mv        (cv_mv),
    .raw32     (cv_raw32)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_CELLS; g++) begin : g_cell
      // Every input is published, whether it holds a cell or a link.
      always_ff @(posedge core_clk) begin
        if (srst) begin
          cell_report[g] <= '0;
        end else if (cv_valid && pend_chan_reg == channel_t'(g)) begin
          cell_report[g].mv        <= cv_mv; // R11
          cell_report[g].raw32     <= cv_raw32; // R11
          cell_report[g].current32 <= {{8{pend_cur_reg[23]}},
                                       pend_cur_reg}; // R12
        end
      end
      // Differential pair g+1 minus g; protections follow cell usage.
      assign cell_prot_enable[g] = cell_in_use[g]; // R10 R2
    end
    for (g = 0; g < 13; g++) begin : g_other
      always_ff @(posedge core_clk) begin
        if (srst) begin
          other_raw[g] <= 32'h0;
        end else if (cv_valid && g >= 5 && g < 11 &&
                     pend_chan_reg == channel_t'(g)) begin
          other_raw[g] <= cv_raw32;
        end else if (cv_valid && g >= 11 && pend_chan_reg == CH_AUX &&
                     32'(aux_lat_reg) == g - 11) begin
          other_raw[g] <= cv_raw32;
        end
      end
    end
  endgenerate

  assign mux_sel       = st_reg.chan;
  assign mux_aux_idx   = st_reg.aux_cur;
  assign conv_start    = st_reg.start;
  assign full_set_done = st_reg.full;
  assign loop_slots    = slots_in_loop;
endmodule
